// *** sim/cfih_flag_sva.sv ***
// port-level assertion checker for the interrupt flag hierarchy
`default_nettype none
module cfih_flag_sva
(
    input wire logic        clk,
    input wire logic        rstn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic        msgSent,
    input wire logic [31:0] fifoIncrement,
    input wire logic        transmitRequest,
    input wire logic        intAnyN,
    input wire logic        intTxN,
    input wire logic        intRxN
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    logic incWr;
    logic qReqWr;
    // increment writes; queue writes with increment and request
    assign incWr = psel && penable && pwrite && paddr == 8'h1C;
    assign qReqWr = psel && penable && pwrite && paddr == 8'h20 && pstrb[1] && pwdata[9:8] == 2'h3;
    // increment pulses follow the written bits, and only increment or queue writes make them
    property p_inc_pulse; incWr && pstrb == 4'hF |=> fifoIncrement == {$past(pwdata[31:1]), 1'b0}; endproperty
    a_inc_pulse: assert property (p_inc_pulse) else $error("increment pulse differs from write");
    property p_inc_cause;
        fifoIncrement != 32'h0 |-> $past(incWr || psel && penable && pwrite && paddr == 8'h20);
    endproperty
    a_inc_cause: assert property (p_inc_cause) else $error("increment pulse without a write");
    // queue request timing around appended messages
    property p_qreq; qReqWr |-> ##2 transmitRequest; endproperty
    a_qreq: assert property (p_qreq) else $error("queued message not requested");
    property p_req_rise; $rose(transmitRequest) |-> $past(qReqWr, 2); endproperty
    a_req_rise: assert property (p_req_rise) else $error("request rose without queue write");
    property p_req_drop; $fell(transmitRequest) |-> $past(msgSent) || $past(msgSent, 2); endproperty
    a_req_drop: assert property (p_req_drop) else $error("request dropped before sending");
    // pins: tx or rx active implies any active; all idle out of reset
    property p_tx_pin; !intTxN |-> !intAnyN; endproperty
    a_tx_pin: assert property (p_tx_pin) else $error("tx pin active without any pin");
    property p_rx_pin; !intRxN |-> !intAnyN; endproperty
    a_rx_pin: assert property (p_rx_pin) else $error("rx pin active without any pin");
    property p_reset_pins; $rose(rstn) |-> intAnyN && intTxN && intRxN; endproperty
    a_reset_pins: assert property (p_reset_pins) else $error("pin active after reset");
endmodule : cfih_flag_sva
bind cfih_flag_hierarchy cfih_flag_sva i_sva
(
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .msgSent(msgSent), .fifoIncrement(fifoIncrement), .transmitRequest(transmitRequest),
    .intAnyN(intAnyN), .intTxN(intTxN), .intRxN(intRxN)
);
`default_nettype wire

// *** sim/cfih_tx_engine.sv ***
// far-side transmit engine model: sends one queued message per gap while requested
`default_nettype none
module cfih_tx_engine
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       transmitRequest,
    input  wire logic [7:0] gap,
    output logic            msgSent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] waitCnt;
    // one message every gap+1 cycles while requested
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            waitCnt <= 8'h00;
            msgSent <= 1'b0;
        end
        else
        begin
            msgSent <= 1'b0;
            if (!transmitRequest)
                waitCnt <= 8'h00;
            else if (waitCnt >= gap)
            begin
                waitCnt <= 8'h00;
                msgSent <= 1'b1;
            end
            else
                waitCnt <= waitCnt + 8'h01;
        end
    end
endmodule : cfih_tx_engine
`default_nettype wire

// *** sim/tb_top.sv ***
// self-checking testbench for the interrupt flag hierarchy
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int DEPTH = 4;
    logic                  clk = 1'b0;
    logic                  rstn = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    cfih_pkg::cfihEvents_t evt = '0;
    cfih_pkg::cfihLevels_t lev = '0;
    logic                  msgSent;
    logic [31:0]           fifoIncrement;
    logic                  transmitRequest;
    logic                  intAnyN;
    logic                  intTxN;
    logic                  intRxN;
    int                    sent = 0;
    int                    mismatches = 0;
    int                    check_count = 0;
    int                    mainBits [6] = '{2, 3, 12, 13, 14, 15};
    int                    evtBits [6] = '{5, 6, 4, 7, 8, 9};
    logic [31:0]           rdq;
    logic                  rde;
    // clock and message counter
    always #2.5 clk = ~clk;
    always @(posedge clk) if (msgSent === 1'b1) sent <= sent + 1;
    cfih_flag_hierarchy #(.QUEUE_DEPTH(DEPTH)) i_dut
    (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt),
        .lev(lev), .msgSent(msgSent), .fifoIncrement(fifoIncrement), .transmitRequest(transmitRequest),
        .intAnyN(intAnyN), .intTxN(intTxN), .intRxN(intRxN)
    );
    cfih_tx_engine i_eng
    (
        .clk(clk), .rstn(rstn), .transmitRequest(transmitRequest), .gap(8'h28), .msgSent(msgSent)
    );
    // verdict and end of run
    task automatic end_of_test();
        $display("mismatches %0d, checks %0d", mismatches, check_count);
        if (mismatches == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one APB transfer: setup, access until pready, then release
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rdq = prdata;
        rde = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rdq, exp);
    endtask : rd
    task automatic pulse(input int k);
        @(posedge clk);
        evt[k] <= 1'b1;
        @(posedge clk);
        evt <= '0;
    endtask : pulse
    // main sequence
    initial
    begin
        logic [31:0] en;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 32'h38; a += 4)
            rd(8'(a), a == 32'h20 ? 32'h0001_0000 : (a == 32'h38 ? 32'h40 : 32'h0));
        bus(1'b0, 8'h3C, 32'h0);
        chk(32'(rde), 32'h1);
        // sticky main flags: hold, clear on zero, drive the any pin
        foreach (mainBits[i])
        begin
            en = 32'h1 << (mainBits[i] + 16);
            wr(8'h00, en);
            pulse(evtBits[i]);
            wr(8'h00, en | 32'h0000_FFFF);
            rd(8'h00, en | (32'h1 << mainBits[i]));
            chk(32'(intAnyN), 32'h0);
            if (mainBits[i] == 12) rd(8'h38, 32'h45);
            wr(8'h00, en);
            repeat (4) @(posedge clk);
            rd(8'h00, en);
            chk(32'(intAnyN), 32'h1);
        end
        rd(8'h38, 32'h40);
        wr(8'h00, 32'h0);
        // receive overrun on object 3, transmit attempt on the queue
        for (int t = 0; t < 2; t++)
        begin
            en = t ? 32'h1 : 32'h8;
            wr(8'h18, en);
            pulse(t ? 11 : 46); // queue attempt or object 3 overrun
            wr(t ? 8'h10 : 8'h0C, 32'h0);
            rd(t ? 8'h10 : 8'h0C, en);
            rd(8'h24 + 8'(4 * t), en);
            rd(8'h00, 32'h1 << (11 - t));
            wr(8'h24 + 8'(4 * t), 32'h0);
            rd(t ? 8'h10 : 8'h0C, 32'h0);
            rd(8'h00, 32'h0);
        end
        // event FIFO, serial and memory summaries
        for (int k = 0; k < 3; k++)
        begin
            en = k ? 32'h100 : 32'h800;
            wr(8'h2C + 8'(4 * k), en);
            pulse(k ? 5 - 2 * k : 10);
            rd(8'h00, 32'h10 << (k ? 6 - k : 0));
            wr(8'h2C + 8'(4 * k), en);
            rd(8'h00, 32'h0);
        end
        // level flag clears once the condition ends
        wr(8'h14, 32'h4);
        lev.rxLevel[2] <= 1'b1;
        wr(8'h00, 32'h0);
        rd(8'h04, 32'h4);
        rd(8'h00, 32'h2);
        wr(8'h1C, 32'h4);
        lev.rxLevel[2] <= 1'b0;
        rd(8'h04, 32'h0);
        rd(8'h00, 32'h0);
        // fill the queue past full while the engine stalls, then drain
        wr(8'h20, 32'h1);
        wr(8'h00, 32'h0003_0000);
        lev.rxLevel[2] <= 1'b1;
        rd(8'h20, 32'h0001_0001);
        chk(32'(intTxN), 32'h0);
        for (int i = 0; i <= DEPTH; i++)
            wr(8'h20, 32'h301);
        rd(8'h20, (32'(DEPTH) << 24) | 32'h1);
        chk(32'(intTxN), 32'h1);
        chk(32'(intRxN), 32'h0);
        lev.rxLevel[2] <= 1'b0;
        while (transmitRequest !== 1'b0) @(posedge clk);
        repeat (4) @(posedge clk);
        chk(32'(sent), 32'(DEPTH));
        chk(32'(intTxN), 32'h0);
        chk(32'(intRxN), 32'h1);
        end_of_test();
    end
    // watchdog against a hung handshake
    initial
    begin
        repeat (5000) @(posedge clk);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire

// *** src/cfih_apb_slave.sv ***
// register bus slave: phase decode, byte lane mask and unmapped address answer
`default_nettype none
`include "cfih_defines.svh"
module cfih_apb_slave
(
    input  wire logic                 clk,
    input  wire logic                 rstn,
    input  wire cfih_pkg::cfihApbReq_t req,
    output logic                      pready,
    output logic                      pslverr,
    output cfih_pkg::cfihBusOp_t      op
);
    logic mapped;

    // word aligned and inside the map
    function automatic logic isMapped(input logic [7:0] a);
        isMapped = (a[1:0] == 2'h0) && (a <= `CFIH_OFS_LAST);
    endfunction : isMapped

    // zero wait state; unmapped addresses answer with an error and are ignored
    always_comb
    begin
        mapped   = isMapped(req.paddr);
        pready   = 1'b1;
        pslverr  = req.psel & req.penable & ~mapped;
        op.setup = req.psel & ~req.penable;
        op.wr    = req.psel & req.penable & req.pwrite & mapped;
        op.addr  = req.paddr;
        op.wdata = req.pwdata;
        op.mask  = {{8{req.pstrb[3]}}, {8{req.pstrb[2]}}, {8{req.pstrb[1]}}, {8{req.pstrb[0]}}};
    end
endmodule : cfih_apb_slave
`default_nettype wire

// *** src/cfih_defines.svh ***
// register offsets, field positions and reset values of the interrupt flag hierarchy
// Notes on behaviour
// RL1: FIFO, queue and event FIFO level flags clear themselves when the condition ends after a FIFO increment.
// RL2: aggregate and main summary flags are read-only and drop only when every flag feeding them is clear.
// RL3: writes to the main transmit and receive summary flags do nothing; they follow the FIFO conditions.
// RL4: a read-only aggregate register holds one bit per object mirroring each receive FIFO overrun flag.
// RL5: a read-only aggregate register holds one bit per object mirroring each transmit attempt flag.
// RL6: the host clears module interrupts, enables queue and FIFO interrupts, then the main summary enables.
// RL7: with queue-not-full and transmit summary enabled, the transmit pin is active while the queue has room.
// RL8: the host checks that the queue is not full before it writes a message into the next free slot.
// RL9: the host sets queue increment and transmit request in one write after loading a message.
// RL10: an increment with a request while the queue is already sending also sends the appended message.
// RL11: writing zero to the system error flag clears it and removes its code from the interrupt code field.
// RL12: a cleared bus error flag stays clear until the next error counter threshold crossing.
// RL13: host-clearable flags stay set until the host writes zero to them.
// RL14: each interrupt pin is active while any set and enabled main flag mapped to it exists.
`ifndef CFIH_DEFINES_SVH
`define CFIH_DEFINES_SVH
// byte offsets on the register bus
`define CFIH_OFS_MAIN     8'h00
`define CFIH_OFS_AGG_RX   8'h04
`define CFIH_OFS_AGG_TX   8'h08
`define CFIH_OFS_AGG_RXOV 8'h0C
`define CFIH_OFS_AGG_TXAT 8'h10
`define CFIH_OFS_FIFO_IE  8'h14
`define CFIH_OFS_FIFO_OVIE 8'h18
`define CFIH_OFS_FIFO_INC 8'h1C
`define CFIH_OFS_QUEUE    8'h20
`define CFIH_OFS_OVFLAG   8'h24
`define CFIH_OFS_ATFLAG   8'h28
`define CFIH_OFS_EVFIFO   8'h2C
`define CFIH_OFS_SERIAL   8'h30
`define CFIH_OFS_ECC      8'h34
`define CFIH_OFS_ICODE    8'h38
`define CFIH_OFS_LAST     8'h38
// main register flag positions, enables sit at flag position plus the shift
`define CFIH_MB_TX   0
`define CFIH_MB_RX   1
`define CFIH_MB_TBC  2
`define CFIH_MB_MOD  3
`define CFIH_MB_TEF  4
`define CFIH_MB_ECC  8
`define CFIH_MB_CRC  9
`define CFIH_MB_TXAT 10
`define CFIH_MB_RXOV 11
`define CFIH_MB_SERR 12
`define CFIH_MB_CERR 13
`define CFIH_MB_WAK  14
`define CFIH_MB_IVM  15
`define CFIH_EN_SHIFT 16
// queue control fields
`define CFIH_QB_NFEN 0
`define CFIH_QB_INC  8
`define CFIH_QB_REQ  9
`define CFIH_QB_NF   16
`define CFIH_QB_CNT  24
// event FIFO and summary register fields
`define CFIH_EB_OV   3
`define CFIH_EB_EN   8
// interrupt code values
`define CFIH_ICODE_SERR 7'h45
`define CFIH_ICODE_NONE 7'h40
`define CFIH_RST_WORD   32'h0000_0000
`define CFIH_QDEPTH_DEF 8
`endif

// *** src/cfih_flag_hierarchy.sv ***
// interrupt flag hierarchy: object flags, aggregates, main register and interrupt pins
//
// Design decisions made here: the address map and register access over APB.
`default_nettype none
`include "cfih_defines.svh"
module cfih_flag_hierarchy
#(
    parameter int QUEUE_DEPTH = `CFIH_QDEPTH_DEF
)
(
    input  wire logic                  clk,
    input  wire logic                  rstn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire cfih_pkg::cfihEvents_t evt,
    input  wire cfih_pkg::cfihLevels_t lev,
    input  wire logic                  msgSent,
    output logic [31:0]                fifoIncrement,
    output logic                       transmitRequest,
    output logic                       intAnyN,
    output logic                       intTxN,
    output logic                       intRxN
);
    // register state of the block apart from the transmit queue state
    typedef struct packed {
        logic [5:0]  sticky;    // ivm wak cerr mod tbc serr
        logic [15:0] mainEn;
        logic [31:0] fifoIe;
        logic [31:0] fifoOvIe;
        logic [31:0] ovFlag;
        logic [31:0] atFlag;
        logic [31:0] levRx;
        logic [31:0] levTx;
        logic [31:0] incPulse;
        logic [2:0]  tefLev;
        logic        tefOv;
        logic [3:0]  tefEn;
        logic [1:0]  crcFlag;
        logic [1:0]  crcEn;
        logic [1:0]  eccFlag;
        logic [1:0]  eccEn;
        logic        qNfEn;
        logic        qInc;
        logic        qReq;
        logic [31:0] rdata;
        logic        intAnyN;
        logic        intTxN;
        logic        intRxN;
    } cfihState_t;

    cfihState_t           s;
    cfihState_t           next_s;
    cfih_pkg::cfihApbReq_t busReq;
    cfih_pkg::cfihBusOp_t  op;
    logic                 qNotFull;
    logic [7:0]           qCount;
    logic [31:0]          aggRx;
    logic [31:0]          aggTx;
    logic [31:0]          aggRxOv;
    logic [31:0]          aggTxAt;
    logic [15:0]          mainFlags;
    logic [15:0]          keepLo;
    logic [6:0]           icode;
    logic                 tefSum;
    logic                 crcSum;
    logic                 eccSum;

    // write with byte lanes applied
    function automatic logic [31:0] mergeW(input logic [31:0] old, input logic [31:0] wd, input logic [31:0] m);
        mergeW = (old & ~m) | (wd & m);
    endfunction : mergeW

    // bits kept by a write-zero-to-clear access; lanes not written keep everything
    function automatic logic [31:0] keepOf(input logic [31:0] wd, input logic [31:0] m);
        keepOf = wd | ~m;
    endfunction : keepOf

    // sticky main flags picked out of a main register image
    function automatic logic [5:0] stickyOf(input logic [15:0] v);
        stickyOf = {v[`CFIH_MB_IVM], v[`CFIH_MB_WAK], v[`CFIH_MB_CERR],
                    v[`CFIH_MB_MOD], v[`CFIH_MB_TBC], v[`CFIH_MB_SERR]};
    endfunction : stickyOf

    // bus slave packing
    assign busReq.psel    = psel;
    assign busReq.penable = penable;
    assign busReq.pwrite  = pwrite;
    assign busReq.paddr   = paddr;
    assign busReq.pwdata  = pwdata;
    assign busReq.pstrb   = pstrb;

    cfih_apb_slave u_apb
    (
        .clk     (clk),
        .rstn    (rstn),
        .req     (busReq),
        .pready  (pready),
        .pslverr (pslverr),
        .op      (op)
    );

    cfih_tx_queue #(.DEPTH(QUEUE_DEPTH)) u_queue
    (
        .clk             (clk),
        .rstn            (rstn),
        .increment       (s.qInc),
        .request         (s.qReq),
        .msgSent         (msgSent),
        .notFull         (qNotFull),
        .transmitRequest (transmitRequest),
        .count           (qCount)
    );

    // aggregates: pure ORs of enabled object flags, bit 0 of the transmit ones is the queue, of the receive ones reserved
    always_comb
    begin
        aggRx   = {s.levRx[31:1] & s.fifoIe[31:1], 1'b0}; // RL2
        aggTx   = {s.levTx[31:1] & s.fifoIe[31:1], qNotFull & s.qNfEn}; // RL2 RL7
        aggRxOv = {s.ovFlag[31:1] & s.fifoOvIe[31:1], 1'b0}; // RL4
        aggTxAt = s.atFlag & s.fifoOvIe; // RL5
        tefSum  = |({s.tefOv, s.tefLev} & s.tefEn); // RL2
        crcSum  = |(s.crcFlag & s.crcEn); // RL2
        eccSum  = |(s.eccFlag & s.eccEn); // RL2
    end

    // main register image; summary bits have no storage of their own
    always_comb
    begin
        mainFlags                = 16'h0000;
        mainFlags[`CFIH_MB_TX]   = |aggTx; // RL3
        mainFlags[`CFIH_MB_RX]   = |aggRx; // RL3
        mainFlags[`CFIH_MB_TXAT] = |aggTxAt; // RL2
        mainFlags[`CFIH_MB_RXOV] = |aggRxOv; // RL2
        mainFlags[`CFIH_MB_TEF]  = tefSum;
        mainFlags[`CFIH_MB_CRC]  = crcSum;
        mainFlags[`CFIH_MB_ECC]  = eccSum;
        mainFlags[`CFIH_MB_IVM]  = s.sticky[5];
        mainFlags[`CFIH_MB_WAK]  = s.sticky[4];
        mainFlags[`CFIH_MB_CERR] = s.sticky[3];
        mainFlags[`CFIH_MB_MOD]  = s.sticky[2];
        mainFlags[`CFIH_MB_TBC]  = s.sticky[1];
        mainFlags[`CFIH_MB_SERR] = s.sticky[0];
        icode = s.sticky[0] ? `CFIH_ICODE_SERR : `CFIH_ICODE_NONE; // RL11
    end

    // next state: bus writes first, hardware events last so a set beats a clear
    always_comb
    begin
        next_s          = s;
        keepLo          = 16'hFFFF;
        next_s.incPulse = '0;
        next_s.qInc     = 1'b0;
        next_s.qReq     = 1'b0;
        // level flags follow the storage conditions, which end after an increment
        next_s.levRx    = {lev.rxLevel[31:1], 1'b0}; // RL1
        next_s.levTx    = {lev.txLevel[31:1], 1'b0}; // RL1
        next_s.tefLev   = lev.tefLevel; // RL1
        if (op.wr)
        begin
            unique case (op.addr)
                `CFIH_OFS_MAIN:
                begin
                    // summary bits ignore writes; sticky ones clear on zero
                    keepLo        = 16'(keepOf(op.wdata, op.mask));
                    next_s.sticky = s.sticky & stickyOf(keepLo); // RL3 RL11 RL12 RL13
                    next_s.mainEn = 16'(mergeW({s.mainEn, 16'h0000}, op.wdata, op.mask) >> `CFIH_EN_SHIFT);
                end
                `CFIH_OFS_FIFO_IE:   next_s.fifoIe   = mergeW(s.fifoIe, op.wdata, op.mask);
                `CFIH_OFS_FIFO_OVIE: next_s.fifoOvIe = mergeW(s.fifoOvIe, op.wdata, op.mask);
                `CFIH_OFS_FIFO_INC:  next_s.incPulse = {op.wdata[31:1] & op.mask[31:1], 1'b0}; // RL1
                `CFIH_OFS_QUEUE:
                begin
                    if (op.mask[`CFIH_QB_NFEN])
                        next_s.qNfEn = op.wdata[`CFIH_QB_NFEN];
                    // increment and request taken in the same write
                    next_s.qInc        = op.wdata[`CFIH_QB_INC] & op.mask[`CFIH_QB_INC]; // RL10
                    next_s.qReq        = op.wdata[`CFIH_QB_REQ] & op.mask[`CFIH_QB_REQ]; // RL10
                    next_s.incPulse[0] = op.wdata[`CFIH_QB_INC] & op.mask[`CFIH_QB_INC]; // RL1
                end
                `CFIH_OFS_OVFLAG: next_s.ovFlag = s.ovFlag & keepOf(op.wdata, op.mask); // RL13
                `CFIH_OFS_ATFLAG: next_s.atFlag = s.atFlag & keepOf(op.wdata, op.mask); // RL13
                `CFIH_OFS_EVFIFO:
                begin
                    next_s.tefOv = s.tefOv & (op.wdata[`CFIH_EB_OV] | ~op.mask[`CFIH_EB_OV]); // RL13
                    if (op.mask[`CFIH_EB_EN])
                        next_s.tefEn = op.wdata[`CFIH_EB_EN +: 4];
                end
                `CFIH_OFS_SERIAL:
                begin
                    next_s.crcFlag = s.crcFlag & (op.wdata[1:0] | ~op.mask[1:0]); // RL13
                    if (op.mask[`CFIH_EB_EN])
                        next_s.crcEn = op.wdata[`CFIH_EB_EN +: 2];
                end
                `CFIH_OFS_ECC:
                begin
                    next_s.eccFlag = s.eccFlag & (op.wdata[1:0] | ~op.mask[1:0]); // RL13
                    if (op.mask[`CFIH_EB_EN])
                        next_s.eccEn = op.wdata[`CFIH_EB_EN +: 2];
                end
                default: ; // aggregates and code register are read-only
            endcase
        end
        // hardware events set sticky flags, winning over a same-cycle clear
        next_s.sticky = next_s.sticky | {evt.invalidMsg, evt.wakeup, evt.busErrorCross,
                                         evt.modeChange, evt.timeBase, evt.systemError}; // RL12 RL13
        next_s.ovFlag  = next_s.ovFlag | {evt.rxOverrun[31:1], 1'b0}; // RL13
        next_s.atFlag  = next_s.atFlag | evt.txAttempt; // RL13
        next_s.tefOv   = next_s.tefOv | evt.tefOverrun; // RL13
        next_s.crcFlag = next_s.crcFlag | {evt.serialChecksum, evt.serialFormat}; // RL13
        next_s.eccFlag = next_s.eccFlag | {evt.doubleBit, evt.singleBit}; // RL13
        // read data captured in the setup cycle
        if (op.setup)
        begin
            unique case (op.addr)
                `CFIH_OFS_MAIN:      next_s.rdata = {s.mainEn, mainFlags};
                `CFIH_OFS_AGG_RX:    next_s.rdata = aggRx; // RL2
                `CFIH_OFS_AGG_TX:    next_s.rdata = aggTx; // RL2
                `CFIH_OFS_AGG_RXOV:  next_s.rdata = aggRxOv; // RL4
                `CFIH_OFS_AGG_TXAT:  next_s.rdata = aggTxAt; // RL5
                `CFIH_OFS_FIFO_IE:   next_s.rdata = s.fifoIe;
                `CFIH_OFS_FIFO_OVIE: next_s.rdata = s.fifoOvIe;
                `CFIH_OFS_QUEUE:     next_s.rdata = {qCount, 7'h00, qNotFull, 15'h0000, s.qNfEn};
                `CFIH_OFS_OVFLAG:    next_s.rdata = s.ovFlag;
                `CFIH_OFS_ATFLAG:    next_s.rdata = s.atFlag;
                `CFIH_OFS_EVFIFO:    next_s.rdata = {20'h00000, s.tefEn, 4'h0, s.tefOv, s.tefLev};
                `CFIH_OFS_SERIAL:    next_s.rdata = {22'h000000, s.crcEn, 6'h00, s.crcFlag};
                `CFIH_OFS_ECC:       next_s.rdata = {22'h000000, s.eccEn, 6'h00, s.eccFlag};
                `CFIH_OFS_ICODE:     next_s.rdata = {25'h0000000, icode}; // RL11
                default:             next_s.rdata = `CFIH_RST_WORD;
            endcase
        end
        // pins: active low while a set and enabled main flag maps to them
        next_s.intAnyN = ~|(mainFlags & s.mainEn); // RL14
        next_s.intTxN  = ~(mainFlags[`CFIH_MB_TX] & s.mainEn[`CFIH_MB_TX]); // RL7 RL14
        next_s.intRxN  = ~(mainFlags[`CFIH_MB_RX] & s.mainEn[`CFIH_MB_RX]); // RL14
    end

    // state register; pins reset inactive high
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            s         <= '0;
            s.intAnyN <= 1'b1;
            s.intTxN  <= 1'b1;
            s.intRxN  <= 1'b1;
        end
        else
            s <= next_s;
    end

    assign prdata        = s.rdata;
    assign fifoIncrement = s.incPulse;
    assign intAnyN       = s.intAnyN;
    assign intTxN        = s.intTxN;
    assign intRxN        = s.intRxN;
endmodule : cfih_flag_hierarchy
`default_nettype wire

// *** src/cfih_pkg.sv ***
// types shared by the interrupt flag hierarchy modules
`default_nettype none
package cfih_pkg;
    // register bus request as seen by the slave
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } cfihApbReq_t;
    // decoded bus operation
    typedef struct packed {
        logic        setup;
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] mask;
    } cfihBusOp_t;
    // one-cycle event pulses from the controller core
    typedef struct packed {
        logic [31:0] rxOverrun;
        logic [31:0] txAttempt;
        logic        tefOverrun;
        logic        invalidMsg;
        logic        wakeup;
        logic        busErrorCross;
        logic        modeChange;
        logic        timeBase;
        logic        systemError;
        logic        serialFormat;
        logic        serialChecksum;
        logic        singleBit;
        logic        doubleBit;
    } cfihEvents_t;
    // FIFO condition levels from the storage logic
    typedef struct packed {
        logic [31:0] rxLevel;
        logic [31:0] txLevel;
        logic [2:0]  tefLevel;
    } cfihLevels_t;
endpackage : cfih_pkg
`default_nettype wire

// *** src/cfih_tx_queue.sv ***
// transmit queue occupancy and transmit request tracking
`default_nettype none
module cfih_tx_queue
#(
    parameter int DEPTH = 8
)
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        increment,
    input  wire logic        request,
    input  wire logic        msgSent,
    output logic             notFull,
    output logic             transmitRequest,
    output logic [7:0]       count
);
    typedef struct packed {
        logic [7:0] count;
        logic       requested;
    } cfihQState_t;

    cfihQState_t s;
    cfihQState_t next_s;
    logic        doInc;
    logic        doSent;

    // appending while sending raises the count so the request holds for the new message
    always_comb
    begin
        next_s = s;
        doInc  = increment && (s.count < 8'(DEPTH));
        doSent = msgSent && (s.count != 8'h00);
        next_s.count = s.count + {7'h00, doInc} - {7'h00, doSent}; // RL10
        next_s.requested = (s.requested | request) && (next_s.count != 8'h00); // RL10
    end

    // state register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            s <= '0;
        else
            s <= next_s;
    end

    assign notFull         = s.count < 8'(DEPTH);
    assign transmitRequest = s.requested;
    assign count           = s.count;
endmodule : cfih_tx_queue
`default_nettype wire
